// >>> design/adc_cmp_pkg.sv
// constants and state type for the result compare and status block
package adc_cmp_pkg;

	localparam int NUM_UNITS   = 4;
	localparam int NUM_MODULES = 19;
	localparam int RES_W       = 12;
	localparam int CNT_W       = 5;

	// register byte offsets
	localparam logic [8:0] OFS_CMP0    = 9'h0e0;
	localparam logic [8:0] OFS_CMP1    = 9'h0e4;
	localparam logic [8:0] OFS_CMP2    = 9'h0e8;
	localparam logic [8:0] OFS_CMP3    = 9'h0ec;
	localparam logic [8:0] OFS_MIRR_LO = 9'h0f0;
	localparam logic [8:0] OFS_MIRR_HI = 9'h0f4;
	localparam logic [8:0] OFS_SUMMARY = 9'h0f8;

	// compare unit fields
	localparam int CMP_THR_LSB  = 16;
	localparam int CMP_WIN_BIT  = 15;
	localparam int CMP_MCNT_LSB = 8;
	localparam int CMP_SEL_LSB  = 3;
	localparam int CMP_DIR_BIT  = 2;
	localparam int CMP_IE_BIT   = 1;
	localparam int CMP_EN_BIT   = 0;
	localparam logic [31:0] CMP_MASK_PAIR = 32'h0fff_8fff;
	localparam logic [31:0] CMP_MASK_SOLO = 32'h0fff_0fff;
	localparam logic [31:0] CMP_RESET     = 32'h0000_0000;

	// summary status fields
	localparam int SUM_IRQF_LSB = 0;
	localparam int SUM_MFLG_LSB = 4;
	localparam int SUM_IOVR_LSB = 8;
	localparam int SUM_LVL_LSB  = 12;
	localparam int SUM_CHAN_LSB = 16;
	localparam int SUM_BUSY_BIT = 23;
	localparam int SUM_AIOV_BIT = 24;
	localparam int SUM_ATRG_BIT = 25;
	localparam int SUM_AVAL_BIT = 26;
	localparam int SUM_AOVR_BIT = 27;

	// mirror fields
	localparam int MIRR_LO_OVR_LSB = 16;
	localparam int MIRR_HI_OVR_LSB = 16;

	localparam logic [CNT_W-1:0] CNT_SAT = 5'h10;

	typedef struct packed {
		logic [NUM_UNITS-1:0][31:0]      cmpCfg;
		logic [NUM_UNITS-1:0][CNT_W-1:0] matchCnt;
		logic [NUM_UNITS-1:0]            matchFlag;
		logic [NUM_UNITS-1:0]            cmpLevel;
		logic [NUM_UNITS-1:0]            irqFlag;
		logic [NUM_UNITS-1:0]            irqOverrun;
		logic [NUM_UNITS-1:0]            cmpIrq;
		logic [31:0]                     rdata;
		logic                            waitReq;
	} state_t;

endpackage

// >>> design/adc_result_compare_status.sv
// result compare units and status aggregation with an avalon-mm slave
`timescale 1ns/1ps
// What this block does
// - each unit holds a 12-bit threshold in bits 27:16, compared to selected result
// - direction 0 matches below threshold, 1 matches at or above
// - match counter counts consecutive matches, resets to zero on a miss
// - match flag sets when counter reaches programmed count plus one
// - compare only while enabled, evaluated when selected result is loaded
// - set match flag with interrupt enable raises a compare interrupt request
// - 5-bit select picks sample module 0 to 18
// - window mode on units 0 and 2 needs both paired units matching
// - window enable bit exists only in units 0 and 2
// - without window, units 0 and 2 flag alone; flags sit in bits 7:4
// - first mirror shows overrun 0-15 in 31:16 and valid in 15:0
// - second mirror shows overrun 16-18 in 18:16 and valid in 2:0
// - summary bit is 1 while any result overrun bit is 1
// - summary bit is 1 while any result valid bit is 1
// - summary bit is 1 while any trigger overrun flag is 1
// - summary bit is 1 while any interrupt-flag overrun bit is 1
// - busy bit is 1 during a conversion
// - 5-bit channel field reports converted channel while busy
// - compare output bit is 1 when result is at or above threshold
// - match flags and overrun bits clear only by writing 1
// - converter interrupt flag sets on its interrupt pulse
module adc_result_compare_status #(
	parameter int NUM_MODULES = adc_cmp_pkg::NUM_MODULES
) (
	input  wire  logic                           core_clk,
	input  wire  logic                           rst_b,
	input  wire  logic [8:0]                     avs_address,
	input  wire  logic                           avs_read,
	input  wire  logic                           avs_write,
	input  wire  logic [31:0]                    avs_writedata,
	input  wire  logic [3:0]                     avs_byteenable,
	output logic [31:0]                          avs_readdata,
	output logic                                 avs_waitrequest,
	input  wire  logic [NUM_MODULES-1:0]         resultLoad,
	input  wire  logic [NUM_MODULES-1:0][11:0]   resultData,
	input  wire  logic [NUM_MODULES-1:0]         resultValid,
	input  wire  logic [NUM_MODULES-1:0]         resultOverrun,
	input  wire  logic [NUM_MODULES-1:0]         triggerOverrun,
	input  wire  logic [3:0]                     converterIrqLine,
	input  wire  logic                           convBusy,
	input  wire  logic [4:0]                     convChannel,
	output logic [3:0]                           compareIrq
);

	localparam int NU = adc_cmp_pkg::NUM_UNITS;
	localparam int CW = adc_cmp_pkg::CNT_W;

	// the select field and both mirrors are laid out for exactly 19 modules
	if (NUM_MODULES != 19) begin : g_bad_modules
		$error("NUM_MODULES must be 19");
	end

	// byte-lane merge limited to implemented bits
	function automatic logic [31:0] laneMerge(
		input logic [31:0] old,
		input logic [31:0] wd,
		input logic [3:0]  be,
		input logic [31:0] mask
	);
		logic [31:0] lanes;
		lanes = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
		laneMerge = (old & ~(lanes & mask)) | (wd & lanes & mask);
	endfunction

	logic              rstMeta;
	logic              rstSync;

	adc_cmp_pkg::state_t state_reg;
	adc_cmp_pkg::state_t state_next;

	// two-stage release; assertion stays asynchronous
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rstMeta <= 1'b0;
			rstSync <= 1'b0;
		end else begin
			rstMeta <= 1'b1;
			rstSync <= rstMeta;
		end
	end

	// per-unit combinational compare
	logic [NU-1:0]          loadEvt;
	logic [NU-1:0]          atOrAbove;
	logic [NU-1:0]          reached;
	logic [NU-1:0][CW-1:0]  cntNext;

	for (genvar u = 0; u < NU; u++) begin : g_unit
		logic [31:0] cfg;
		logic [4:0]  sel;
		logic [11:0] thr;
		logic [3:0]  mcnt;
		logic        selOk;
		logic [11:0] value;
		logic        match;

		assign cfg   = state_reg.cmpCfg[u];
		assign sel   = cfg[adc_cmp_pkg::CMP_SEL_LSB +: 5];
		assign thr   = cfg[adc_cmp_pkg::CMP_THR_LSB +: 12];
		assign mcnt  = cfg[adc_cmp_pkg::CMP_MCNT_LSB +: 4];
		// codes above 18 select nothing
		assign selOk = (sel < 5'(NUM_MODULES));
		assign value = selOk ? resultData[sel] : 12'h000;
		assign loadEvt[u] = cfg[adc_cmp_pkg::CMP_EN_BIT]
			& selOk & resultLoad[sel];
		assign atOrAbove[u] = (value >= thr);
		assign match = cfg[adc_cmp_pkg::CMP_DIR_BIT] ?
			atOrAbove[u] : ~atOrAbove[u];

		always_comb begin
			cntNext[u] = state_reg.matchCnt[u];
			if (!cfg[adc_cmp_pkg::CMP_EN_BIT]) begin
				cntNext[u] = '0;
			end else if (loadEvt[u]) begin
				if (!match) begin
					cntNext[u] = '0;
				end else if (state_reg.matchCnt[u]
					!= adc_cmp_pkg::CNT_SAT) begin
					// saturates so a long run keeps the flag re-arming
					cntNext[u] = state_reg.matchCnt[u] + 5'h01;
				end
			end
		end

		// count has reached target plus one
		assign reached[u] = loadEvt[u] & match
			& (cntNext[u] > {1'b0, mcnt});
	end

	// unit flag set conditions including window pairing
	logic [NU-1:0] flagSet;

	always_comb begin
		flagSet = reached;
		for (int p = 0; p < NU; p += 2) begin
			if (state_reg.cmpCfg[p][adc_cmp_pkg::CMP_WIN_BIT]) begin
				// pair counts as matched when both counters sit above their target
				flagSet[p] = (loadEvt[p] | loadEvt[p+1])
					& (cntNext[p] > {1'b0,
					state_reg.cmpCfg[p][adc_cmp_pkg::CMP_MCNT_LSB +: 4]})
					& (cntNext[p+1] > {1'b0,
					state_reg.cmpCfg[p+1][adc_cmp_pkg::CMP_MCNT_LSB +: 4]}
					);
			end
		end
	end

	// status words
	logic [31:0] mirrorLo;
	logic [31:0] mirrorHi;
	logic [31:0] summary;

	always_comb begin
		mirrorLo = {resultOverrun[15:0], resultValid[15:0]};
		mirrorHi = '0;
		mirrorHi[adc_cmp_pkg::MIRR_HI_OVR_LSB +: 3] =
			resultOverrun[18:16];
		mirrorHi[2:0] = resultValid[18:16];
		summary = '0;
		summary[adc_cmp_pkg::SUM_IRQF_LSB +: 4] = state_reg.irqFlag;
		summary[adc_cmp_pkg::SUM_MFLG_LSB +: 4] = state_reg.matchFlag;
		summary[adc_cmp_pkg::SUM_IOVR_LSB +: 4] = state_reg.irqOverrun;
		summary[adc_cmp_pkg::SUM_LVL_LSB +: 4] = state_reg.cmpLevel;
		summary[adc_cmp_pkg::SUM_CHAN_LSB +: 5] = convChannel;
		summary[adc_cmp_pkg::SUM_BUSY_BIT] = convBusy;
		summary[adc_cmp_pkg::SUM_AIOV_BIT] = |state_reg.irqOverrun;
		summary[adc_cmp_pkg::SUM_ATRG_BIT] = |triggerOverrun;
		summary[adc_cmp_pkg::SUM_AVAL_BIT] = |resultValid;
		summary[adc_cmp_pkg::SUM_AOVR_BIT] = |resultOverrun;
	end

	// bus access decode
	logic        busReq;
	logic        wrDone;
	logic [8:0]  wordAddr;
	logic [31:0] w1cLanes;

	assign busReq   = avs_read | avs_write;
	// the write lands at the edge where waitrequest is seen low
	assign wrDone   = avs_write & ~state_reg.waitReq;
	assign wordAddr = {avs_address[8:2], 2'b00};
	assign w1cLanes = avs_writedata & {{8{avs_byteenable[3]}},
		{8{avs_byteenable[2]}}, {8{avs_byteenable[1]}},
		{8{avs_byteenable[0]}}};

	always_comb begin
		logic [3:0] clrFlag;
		logic [3:0] clrIrq;
		logic [3:0] clrOvr;
		state_next = state_reg;
		clrFlag = '0;
		clrIrq  = '0;
		clrOvr  = '0;

		// one wait cycle per access, then the answer
		state_next.waitReq = ~(busReq & state_reg.waitReq);
		if (avs_read & state_reg.waitReq) begin
			case (wordAddr)
				adc_cmp_pkg::OFS_CMP0:    state_next.rdata = state_reg.cmpCfg[0];
				adc_cmp_pkg::OFS_CMP1:    state_next.rdata = state_reg.cmpCfg[1];
				adc_cmp_pkg::OFS_CMP2:    state_next.rdata = state_reg.cmpCfg[2];
				adc_cmp_pkg::OFS_CMP3:    state_next.rdata = state_reg.cmpCfg[3];
				adc_cmp_pkg::OFS_MIRR_LO: state_next.rdata = mirrorLo;
				adc_cmp_pkg::OFS_MIRR_HI: state_next.rdata = mirrorHi;
				adc_cmp_pkg::OFS_SUMMARY: state_next.rdata = summary;
				default:                  state_next.rdata = 32'h0000_0000;
			endcase
		end

		if (wrDone) begin
			case (wordAddr)
				adc_cmp_pkg::OFS_CMP0: begin
					state_next.cmpCfg[0] = laneMerge(state_reg.cmpCfg[0],
						avs_writedata, avs_byteenable,
						adc_cmp_pkg::CMP_MASK_PAIR);
				end
				adc_cmp_pkg::OFS_CMP1: begin
					state_next.cmpCfg[1] = laneMerge(state_reg.cmpCfg[1],
						avs_writedata, avs_byteenable,
						adc_cmp_pkg::CMP_MASK_SOLO);
				end
				adc_cmp_pkg::OFS_CMP2: begin
					state_next.cmpCfg[2] = laneMerge(state_reg.cmpCfg[2],
						avs_writedata, avs_byteenable,
						adc_cmp_pkg::CMP_MASK_PAIR);
				end
				adc_cmp_pkg::OFS_CMP3: begin
					state_next.cmpCfg[3] = laneMerge(state_reg.cmpCfg[3],
						avs_writedata, avs_byteenable,
						adc_cmp_pkg::CMP_MASK_SOLO);
				end
				adc_cmp_pkg::OFS_SUMMARY: begin
					clrIrq  = w1cLanes[adc_cmp_pkg::SUM_IRQF_LSB +: 4];
					clrFlag = w1cLanes[adc_cmp_pkg::SUM_MFLG_LSB +: 4];
					clrOvr  = w1cLanes[adc_cmp_pkg::SUM_IOVR_LSB +: 4];
				end
				default: begin
					// unmapped and read-only words ignore writes
				end
			endcase
		end

		state_next.matchCnt = cntNext;
		for (int u = 0; u < NU; u++) begin
			// level follows every load of the selected result while the unit is enabled
			if (loadEvt[u]) begin
				state_next.cmpLevel[u] = atOrAbove[u];
			end
		end

		// a set in the same cycle as a clear wins
		state_next.matchFlag = (state_reg.matchFlag & ~clrFlag)
			| flagSet;
		state_next.irqOverrun = (state_reg.irqOverrun & ~clrOvr)
			| (converterIrqLine & state_reg.irqFlag);
		state_next.irqFlag = (state_reg.irqFlag & ~clrIrq)
			| converterIrqLine;
		state_next.cmpIrq = state_next.matchFlag & {
			state_next.cmpCfg[3][adc_cmp_pkg::CMP_IE_BIT],
			state_next.cmpCfg[2][adc_cmp_pkg::CMP_IE_BIT],
			state_next.cmpCfg[1][adc_cmp_pkg::CMP_IE_BIT],
			state_next.cmpCfg[0][adc_cmp_pkg::CMP_IE_BIT]};
	end

	always_ff @(posedge core_clk or negedge rstSync) begin
		if (!rstSync) begin
			state_reg            <= '0;
			state_reg.cmpCfg     <= {NU{adc_cmp_pkg::CMP_RESET}};
			state_reg.waitReq    <= 1'b1;
		end else begin
			state_reg <= state_next;
		end
	end

	assign avs_readdata    = state_reg.rdata;
	assign avs_waitrequest = state_reg.waitReq;
	assign compareIrq      = state_reg.cmpIrq;

endmodule // adc_result_compare_status

// >>> verif/adc_cmp_sva.sv
// port assertions for the result compare and status block
`timescale 1ns/1ps
module adc_cmp_sva #(
	parameter int NUM_MODULES = 19
) (
	input	wire logic						core_clk,
	input	wire logic						rst_b,
	input	wire logic [8:0]				avs_address,
	input	wire logic						avs_read,
	input	wire logic						avs_write,
	input	wire logic [31:0]				avs_readdata,
	input	wire logic						avs_waitrequest,
	input	wire logic [NUM_MODULES-1:0]	resultLoad,
	input	wire logic [NUM_MODULES-1:0]	resultValid,
	input	wire logic [NUM_MODULES-1:0]	resultOverrun,
	input	wire logic [NUM_MODULES-1:0]	triggerOverrun,
	input	wire logic						convBusy,
	input	wire logic [4:0]				convChannel,
	input	wire logic [3:0]				compareIrq
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	// levels must sit still across a read, else the mirror may lag
	wire logic [3*NUM_MODULES+5:0]	lv = {resultValid, resultOverrun,
		triggerOverrun, convBusy, convChannel};
	wire logic						rd = avs_read && !avs_waitrequest;

	a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest
		|=> !avs_waitrequest) else $error("request not answered in time");
	a_wait_pulse: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low too long");
	a_irq_rise: assert property (
		(compareIrq & ~$past(compareIrq)) != 4'h0
		|-> $past(resultLoad) != '0 || $past(avs_write))
		else $error("compare irq rose without cause");
	a_irq_fall: assert property (
		(~compareIrq & $past(compareIrq)) != 4'h0 |-> $past(avs_write))
		else $error("compare irq fell without a write");
	a_unmapped_zero: assert property (rd && (avs_address[8:2] < 7'h38
		|| avs_address[8:2] == 7'h3f) |-> avs_readdata == 32'h0)
		else $error("unmapped read not zero");
	a_mirror_low: assert property (
		rd && avs_address == 9'h0f0 && $stable(lv)
		|-> avs_readdata == {resultOverrun[15:0], resultValid[15:0]})
		else $error("low mirror wrong");
	a_mirror_high: assert property (
		rd && avs_address == 9'h0f4 && $stable(lv) |-> avs_readdata ==
		{13'h0, resultOverrun[18:16], 13'h0, resultValid[18:16]})
		else $error("high mirror wrong");
	a_summary_live: assert property (
		rd && avs_address == 9'h0f8 && $stable(lv) |-> avs_readdata[27:16] ==
		{|resultOverrun, |resultValid, |triggerOverrun, avs_readdata[24],
		convBusy, 2'h0, convChannel}) else $error("summary levels wrong");
	a_ovr_summary: assert property (
		rd && avs_address == 9'h0f8
		|-> avs_readdata[24] == |avs_readdata[11:8])
		else $error("overrun summary wrong");
endmodule // adc_cmp_sva

bind adc_result_compare_status adc_cmp_sva #(.NUM_MODULES(NUM_MODULES)) u_sva (
	.core_clk, .rst_b, .avs_address, .avs_read, .avs_write, .avs_readdata,
	.avs_waitrequest, .resultLoad, .resultValid, .resultOverrun,
	.triggerOverrun, .convBusy, .convChannel, .compareIrq);

// >>> verif/sample_source.sv
// upstream sample modules: result loads, levels and interrupt pulses
`timescale 1ns/1ps
module sample_source #(
	parameter int N = 19
) (
	input	wire logic			core_clk,
	output	logic [N-1:0]		resultLoad,
	output	logic [N-1:0][11:0]	resultData,
	output	logic [N-1:0]		resultValid,
	output	logic [N-1:0]		resultOverrun,
	output	logic [N-1:0]		triggerOverrun,
	output	logic [3:0]			converterIrqLine,
	output	logic				convBusy,
	output	logic [4:0]			convChannel
);
	initial begin
		{resultLoad, resultData, resultValid, resultOverrun} = '0;
		{triggerOverrun, converterIrqLine, convBusy, convChannel} = '0;
	end
	// data flips after the load so a late sample never sees a stale match
	task automatic load(int m, logic [11:0] d);
		resultLoad[m] <= 1'b1;
		resultData[m] <= d;
		@(posedge core_clk);
		resultLoad[m] <= 1'b0;
		resultData[m] <= ~d;
		@(posedge core_clk);
	endtask
	task automatic pulse(int k);
		converterIrqLine[k] <= 1'b1;
		@(posedge core_clk);
		converterIrqLine[k] <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic levels(logic [N-1:0] v, o, t, logic b, logic [4:0] c);
		resultValid <= v;
		resultOverrun <= o;
		triggerOverrun <= t;
		convBusy <= b;
		convChannel <= c;
		@(posedge core_clk);
	endtask
endmodule // sample_source

// >>> verif/tb.sv
// self-checking bench for the result compare and status block
`timescale 1ns/1ps
module tb;
	logic				core_clk = 1'b0;
	logic				rst_b = 1'b0;
	logic [8:0]			avs_address = 9'h0;
	logic				avs_read = 1'b0;
	logic				avs_write = 1'b0;
	logic [31:0]		avs_writedata = 32'h0;
	logic [3:0]			avs_byteenable = 4'hf;
	logic [31:0]		avs_readdata;
	logic				avs_waitrequest;
	logic [18:0]		resultLoad, resultValid, resultOverrun, triggerOverrun;
	logic [18:0][11:0]	resultData;
	logic [3:0]			converterIrqLine, compareIrq;
	logic				convBusy;
	logic [4:0]			convChannel;
	int					mismatches = 0;
	int					cmp_count = 0;
	int					seed = 74;
	int					cnt [4] = '{default: 0};
	logic [31:0]		cfg [4] = '{default: 32'h0};
	logic [3:0]			flg = 4'h0, lvl = 4'h0, iflg = 4'h0, iovr = 4'h0;
	logic [8:0]			ofs [9] = '{9'h0e0, 9'h0e4, 9'h0e8, 9'h0ec, 9'h0f0,
		9'h0f4, 9'h0f8, 9'h000, 9'h0fc};

	always #20 core_clk = ~core_clk;
	sample_source u_src (.core_clk, .resultLoad, .resultData, .resultValid,
		.resultOverrun, .triggerOverrun, .converterIrqLine, .convBusy,
		.convChannel);
	adc_result_compare_status u_dut (.core_clk, .rst_b, .avs_address,
		.avs_read, .avs_write, .avs_writedata, .avs_byteenable, .avs_readdata,
		.avs_waitrequest, .resultLoad, .resultData, .resultValid,
		.resultOverrun, .triggerOverrun, .converterIrqLine, .convBusy,
		.convChannel, .compareIrq);

	task automatic tally_and_finish();
		$display("comparisons %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk_reg(logic [31:0] got, logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %0t reg got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chk_irq(logic [3:0] got, logic [3:0] exp);
		cmp_count++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %0t irq got %h exp %h", $time, got, exp);
		end
	endtask
	function automatic logic [31:0] expect_reg(logic [8:0] a);
		case (a)
			9'h0e0, 9'h0e4, 9'h0e8, 9'h0ec: return cfg[a[3:2]];
			9'h0f0: return {resultOverrun[15:0], resultValid[15:0]};
			9'h0f4: return {13'h0, resultOverrun[18:16], 13'h0, resultValid[18:16]};
			9'h0f8: return {4'h0, |resultOverrun, |resultValid, |triggerOverrun,
				|iovr, convBusy, 2'h0, convChannel, lvl, iovr, flg, iflg};
			default: return 32'h0;
		endcase
	endfunction
	task automatic bus(logic wr, logic [8:0] a, logic [31:0] d, logic [3:0] be,
			output logic [31:0] q);
		int n;
		avs_address <= a;
		avs_writedata <= d;
		avs_byteenable <= be;
		avs_write <= wr;
		avs_read <= !wr;
		n = 0;
		do begin
			@(posedge core_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 40);
		if (n >= 40) begin
			mismatches++;
			tally_and_finish();
		end
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge core_clk);
	endtask
	task automatic sweep();
		logic [31:0] q;
		foreach (ofs[i]) begin
			bus(1'b0, ofs[i], 32'h0, 4'hf, q);
			chk_reg(q, expect_reg(ofs[i]));
		end
	endtask
	task automatic wr(logic [8:0] a, logic [31:0] d, logic [3:0] be);
		logic [31:0] q, m;
		m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
		bus(1'b1, a, d, be, q);
		if (a[8:4] == 5'h0e) begin
			cfg[a[3:2]] = (cfg[a[3:2]] & ~m | d & m)
				& (a[2] ? 32'h0fff_0fff : 32'h0fff_8fff);
			if (!cfg[a[3:2]][0]) cnt[a[3:2]] = 0;
		end
		if (a == 9'h0f8) begin
			iflg &= ~(d[3:0] & m[3:0]);
			flg &= ~(d[7:4] & m[7:4]);
			iovr &= ~(d[11:8] & m[11:8]);
		end
	endtask
	task automatic drive_load(int m, logic [11:0] d);
		logic [3:0] hit, own;
		hit = 4'h0;
		for (int u = 0; u < 4; u++) begin
			if (!cfg[u][0]) cnt[u] = 0;
			else if (cfg[u][7:3] == m) begin
				hit[u] = 1'b1;
				lvl[u] = d >= cfg[u][27:16];
				if ((d >= cfg[u][27:16]) == cfg[u][2])
					cnt[u] = cnt[u] < 16 ? cnt[u] + 1 : 16;
				else
					cnt[u] = 0;
			end
			own[u] = cnt[u] > cfg[u][11:8];
		end
		for (int u = 0; u < 4; u++)
			if (u % 2 == 0 && cfg[u][15]) begin
				if ((hit[u] || hit[u+1]) && own[u] && own[u+1]) flg[u] = 1'b1;
			end else if (hit[u] && own[u]) flg[u] = 1'b1;
		u_src.load(m, d);
		chk_irq(compareIrq, flg & {cfg[3][1], cfg[2][1], cfg[1][1], cfg[0][1]});
	endtask

	initial begin
		repeat (20) @(posedge core_clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge core_clk);
		sweep();
		for (int u = 0; u < 4; u++) begin
			wr(ofs[u], 32'hffff_ffff, 4'hf);
			sweep();
			wr(ofs[u], 32'h0, 4'hf);
		end
		for (int it = 0; it < 12; it++) begin
			logic [31:0] c;
			c = $random(seed);
			c[7:3] = it == 6 ? 5'h1f : 5'($unsigned($random(seed)) % 19);
			c[11:8] = it == 11 ? 4'hf : 4'(it % 4);
			c[0] = it % 5 != 4;
			wr(ofs[it % 4], c, it == 3 ? 4'h5 : 4'hf);
			u_src.levels(19'($random(seed)), 19'($random(seed)),
				19'($random(seed)), 1'($random(seed)),
				5'($unsigned($random(seed)) % 19));
			for (int k = 0; k < 40; k++) begin
				int u, m;
				logic [11:0] thr, d;
				u = $unsigned($random(seed)) % 4;
				thr = cfg[u][27:16];
				m = cfg[u][7:3] < 19 ? cfg[u][7:3] : $unsigned($random(seed)) % 19;
				d = ((($random(seed) & 15) != 0) == cfg[u][2]) ? thr : thr - 12'h1;
				drive_load(m, d);
				if (($random(seed) & 7) == 0) begin
					m = $unsigned($random(seed)) % 4;
					u_src.pulse(m);
					if (iflg[m]) iovr[m] = 1'b1;
					iflg[m] = 1'b1;
				end
			end
			sweep();
			wr(9'h0f8, 32'h0, 4'hf);
			sweep();
			wr(9'h0f8, $random(seed), 4'hf);
			sweep();
		end
		tally_and_finish();
	end
endmodule // tb
